// [bvd_far_model.sv]
module bvd_far_model (
  input wire logic sys_clk, // clock
  output bvd_pkg::bvd_req_t req_in, // request to bridge
  output bvd_pkg::bvd_abort_t abort_in // abort seen by bridge
);
  initial begin
    req_in = '0;
    abort_in = '0;
  end
  // one-cycle request, stale fields inverted once released
  task automatic send_req(input logic io, up, win, input logic [31:0] a);
    req_in <= '{1'b1, io, up, a, win};
    @(posedge sys_clk);
    req_in <= '{1'b0, ~io, ~up, ~a, ~win};
  endtask
  // one-cycle abort event
  task automatic send_abort(input logic posted, rd);
    abort_in <= '{1'b1, 1'b1, posted, rd};
    @(posedge sys_clk);
    abort_in <= '{1'b0, 1'b0, ~posted, ~rd};
  endtask
endmodule

// [bvd_pkg.sv]
package bvd_pkg;
  // register byte offsets
  localparam logic [3:0] BVD_OFF_CTRL = 4'h0;
  localparam logic [3:0] BVD_OFF_STAT = 4'h4;
  localparam logic [3:0] BVD_OFF_MASK = 4'h8;
  // control register field positions
  localparam int BVD_BIT_SERR = 17;
  localparam int BVD_BIT_VGA = 19;
  localparam int BVD_BIT_V16 = 20;
  localparam int BVD_BIT_ABRT = 21;
  localparam int BVD_BIT_IOEN = 0;
  localparam int BVD_BIT_MEMEN = 1;
  localparam int BVD_BIT_ISA = 18;
  localparam int BVD_BIT_AER = 2;
  localparam int BVD_BIT_FATAL = 3;
  localparam logic [31:0] BVD_CTRL_WMASK = 32'h003e_000f;
  localparam logic [31:0] BVD_CTRL_RST = 32'h0000_0000;
  // status bits
  localparam int BVD_ST_URTA = 0;
  localparam int BVD_ST_DROP = 1;
  localparam int BVD_ST_MSG = 2;
  localparam int BVD_ST_BLK = 3;
  localparam int BVD_NST = 4;
  // legacy video windows
  localparam logic [31:0] BVD_VMEM_LO = 32'h000a_0000;
  localparam logic [31:0] BVD_VMEM_HI = 32'h000b_ffff;
  localparam logic [9:0] BVD_VIO_A_LO = 10'h3b0;
  localparam logic [9:0] BVD_VIO_A_HI = 10'h3bb;
  localparam logic [9:0] BVD_VIO_B_LO = 10'h3c0;
  localparam logic [9:0] BVD_VIO_B_HI = 10'h3df;
  localparam logic [15:0] BVD_IO_UPPER = 16'h0000;
  localparam logic [5:0] BVD_IO_ALIAS = 6'h00;
  localparam logic [31:0] BVD_ALL_ONES = 32'hffff_ffff;
  // decode request
  typedef struct packed {
    logic valid;
    logic is_io;
    logic upstream;
    logic [31:0] addr;
    logic in_window;
  } bvd_req_t;
  // abort event
  typedef struct packed {
    logic valid;
    logic from_pcie_ur;
    logic posted;
    logic is_read;
  } bvd_abort_t;
  // abort verdict
  typedef struct packed {
    logic valid;
    logic ret_ones;
    logic target_abort;
    logic complete_ok;
    logic discard;
    logic msg_nonfatal;
    logic msg_fatal;
  } bvd_verdict_t;
endpackage

// [bvd_top.sv]
// Summary of operation
// - mode clear, PCI mode: UR gives all-ones read data, I/O writes complete normally
// - mode clear: master-aborted posted write is dropped silently, no error
// - mode set, PCI mode: UR completion signalled to PCI master as target-abort
// - mode set: aborted posted write sends nonfatal or fatal message if system-error enabled
// - decode-width select 1 decodes full 16 bits, 0 decodes 10 bits
// - decode-width select matters only while video forwarding is enabled
// - video forwarding forwards memory in the legacy frame-buffer window downstream
// - video forwarding forwards I/O with zero upper half in the video port ranges
// - 10-bit decoding ignores address bits 15 to 10
// - video forwarding blocks upstream requests to legacy video addresses
// - video forwarding ignores ISA control and base/limit windows
// - downstream video forwarding still needs memory and I/O space enables
// - video forwarding off: downstream video addresses pass only inside configured windows, upstream ones only outside them
// - master-abort on either side handled per the abort-report mode
module bvd_top (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire bvd_pkg::bvd_req_t req_in, // decode request
  output logic req_fwd, // request forwarded
  output logic req_blk, // request refused
  output logic req_done, // decode verdict valid
  input wire logic pci_mode, // secondary in PCI mode
  input wire bvd_pkg::bvd_abort_t abort_in, // abort event
  output bvd_pkg::bvd_verdict_t verdict, // abort handling
  output logic [31:0] abort_rdata, // read data for aborted read
  output logic irq // level interrupt
);
  logic [31:0] ctrl;
  logic [bvd_pkg::BVD_NST-1:0] stat;
  logic [bvd_pkg::BVD_NST-1:0] mask;
  logic acc_pend;
  logic [bvd_pkg::BVD_NST-1:0] ev;
  logic [bvd_pkg::BVD_NST-1:0] w1c;
  logic [31:0] wbits;
  logic vga_en;
  logic v16;
  logic mode;
  logic vmem_hit;
  logic vio_hit;
  logic vhit;
  logic space_en;
  logic next_fwd;
  logic next_blk;
  bvd_pkg::bvd_verdict_t next_verdict;
  // bus strobes: take on the first edge, commit on the answer edge
  logic acc_req;
  logic acc_take;
  logic rd_take;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  // sticky status as it will stand after this edge
  logic [bvd_pkg::BVD_NST-1:0] next_stat;
  // pieces of the legacy video I/O match
  logic vio_upper_ok;
  logic vio_alias_ok;
  logic vio_a_hit;
  logic vio_b_hit;
  logic [9:0] vio_low;

  // status and mask are written through byte lane 0 only
  if (bvd_pkg::BVD_NST > 8) begin : g_chk_nst
    $error("status field does not fit byte lane 0");
  end
  // every control field must sit inside the 32-bit register
  if (bvd_pkg::BVD_BIT_ABRT > 31 || bvd_pkg::BVD_BIT_V16 > 31 || bvd_pkg::BVD_BIT_VGA > 31) begin : g_chk_vfld
    $error("video or abort field outside the control register");
  end
  if (bvd_pkg::BVD_BIT_SERR > 31 || bvd_pkg::BVD_BIT_FATAL > 31 || bvd_pkg::BVD_BIT_AER > 31) begin : g_chk_efld
    $error("error field outside the control register");
  end
  // the three software fields must be writable
  if (bvd_pkg::BVD_CTRL_WMASK[bvd_pkg::BVD_BIT_ABRT] != 1'b1 ||
      bvd_pkg::BVD_CTRL_WMASK[bvd_pkg::BVD_BIT_V16] != 1'b1 ||
      bvd_pkg::BVD_CTRL_WMASK[bvd_pkg::BVD_BIT_VGA] != 1'b1) begin : g_chk_wmask
    $error("software fields missing from the write mask");
  end
  // the space enables must be writable as well
  if (bvd_pkg::BVD_CTRL_WMASK[bvd_pkg::BVD_BIT_IOEN] != 1'b1 ||
      bvd_pkg::BVD_CTRL_WMASK[bvd_pkg::BVD_BIT_MEMEN] != 1'b1) begin : g_chk_space
    $error("space enables missing from the write mask");
  end
  // software fields come out of reset cleared
  if (bvd_pkg::BVD_CTRL_RST[bvd_pkg::BVD_BIT_ABRT] != 1'b0 ||
      bvd_pkg::BVD_CTRL_RST[bvd_pkg::BVD_BIT_V16] != 1'b0 ||
      bvd_pkg::BVD_CTRL_RST[bvd_pkg::BVD_BIT_VGA] != 1'b0) begin : g_chk_rst
    $error("software fields not cleared by reset");
  end
  // the video windows must be ordered
  if (bvd_pkg::BVD_VIO_A_LO > bvd_pkg::BVD_VIO_A_HI || bvd_pkg::BVD_VIO_B_LO > bvd_pkg::BVD_VIO_B_HI) begin : g_chk_vio
    $error("video I/O range bounds reversed");
  end
  if (bvd_pkg::BVD_VMEM_LO > bvd_pkg::BVD_VMEM_HI) begin : g_chk_vmem
    $error("video memory window bounds reversed");
  end
  // the three registers need distinct offsets
  if (bvd_pkg::BVD_OFF_CTRL == bvd_pkg::BVD_OFF_STAT || bvd_pkg::BVD_OFF_CTRL == bvd_pkg::BVD_OFF_MASK ||
      bvd_pkg::BVD_OFF_STAT == bvd_pkg::BVD_OFF_MASK) begin : g_chk_off
    $error("register offsets overlap");
  end
  // every status event needs a bit inside the status field
  if (bvd_pkg::BVD_ST_URTA >= bvd_pkg::BVD_NST || bvd_pkg::BVD_ST_DROP >= bvd_pkg::BVD_NST ||
      bvd_pkg::BVD_ST_MSG >= bvd_pkg::BVD_NST || bvd_pkg::BVD_ST_BLK >= bvd_pkg::BVD_NST) begin : g_chk_st
    $error("status event outside the status field");
  end

  // byte enables widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign wbits[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  assign vga_en = ctrl[bvd_pkg::BVD_BIT_VGA];
  assign v16 = ctrl[bvd_pkg::BVD_BIT_V16];
  assign mode = ctrl[bvd_pkg::BVD_BIT_ABRT];

  // an access is taken while no answer is pending and committed on the answer edge
  assign acc_req = avs_read | avs_write;
  assign acc_take = acc_req & ~acc_pend;
  assign rd_take = avs_read & ~acc_pend;
  // register selects for the commit edge
  assign wr_ctrl = avs_write & acc_pend & (avs_address == bvd_pkg::BVD_OFF_CTRL);
  assign wr_stat = avs_write & acc_pend & avs_byteenable[0] & (avs_address == bvd_pkg::BVD_OFF_STAT);
  assign wr_mask = avs_write & acc_pend & avs_byteenable[0] & (avs_address == bvd_pkg::BVD_OFF_MASK);

  // one wait cycle per access, answer on the second edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_pend <= 1'b0;
    end else begin
      acc_pend <= acc_take;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~acc_take; // low for exactly the answer cycle
    end
  end

  // control register, writable fields only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= bvd_pkg::BVD_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= (ctrl & ~(wbits & bvd_pkg::BVD_CTRL_WMASK)) |
              (avs_writedata & wbits & bvd_pkg::BVD_CTRL_WMASK);
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= avs_writedata[bvd_pkg::BVD_NST-1:0];
    end
  end

  // sticky status, set wins over write-one-clear
  assign w1c = wr_stat ? avs_writedata[bvd_pkg::BVD_NST-1:0] : '0;
  assign ev[bvd_pkg::BVD_ST_URTA] = next_verdict.target_abort;
  assign ev[bvd_pkg::BVD_ST_DROP] = next_verdict.discard;
  assign ev[bvd_pkg::BVD_ST_MSG] = next_verdict.msg_nonfatal | next_verdict.msg_fatal;
  assign ev[bvd_pkg::BVD_ST_BLK] = next_blk;
  // a new event in the clearing cycle keeps its bit set
  assign next_stat = (stat & ~w1c) | ev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat <= next_stat;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_stat & mask); // level, follows the status it reflects
    end
  end

  // read data mux, unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      unique case (avs_address)
        bvd_pkg::BVD_OFF_CTRL: avs_readdata <= ctrl;
        bvd_pkg::BVD_OFF_STAT: avs_readdata <= {{(32-bvd_pkg::BVD_NST){1'b0}}, stat};
        bvd_pkg::BVD_OFF_MASK: avs_readdata <= {{(32-bvd_pkg::BVD_NST){1'b0}}, mask};
        default: avs_readdata <= '0;
      endcase
    end
  end

  // legacy video I/O match, split into its terms
  assign vio_low = req_in.addr[9:0];
  assign vio_upper_ok = (req_in.addr[31:16] == bvd_pkg::BVD_IO_UPPER);
  // 16-bit decode needs the alias bits clear, 10-bit decode ignores them
  assign vio_alias_ok = ~v16 | (req_in.addr[15:10] == bvd_pkg::BVD_IO_ALIAS);
  assign vio_a_hit = (vio_low >= bvd_pkg::BVD_VIO_A_LO) && (vio_low <= bvd_pkg::BVD_VIO_A_HI);
  assign vio_b_hit = (vio_low >= bvd_pkg::BVD_VIO_B_LO) && (vio_low <= bvd_pkg::BVD_VIO_B_HI);

  // memory window match and final video hit
  always_comb begin
    vmem_hit = (req_in.addr >= bvd_pkg::BVD_VMEM_LO) && (req_in.addr <= bvd_pkg::BVD_VMEM_HI);
    vio_hit = vio_upper_ok && vio_alias_ok && (vio_a_hit || vio_b_hit);
    // width select only reaches the verdict through vhit, so it is inert with forwarding off
    vhit = vga_en && (req_in.is_io ? vio_hit : vmem_hit);
  end

  // forwarding decision
  always_comb begin
    space_en = req_in.is_io ? ctrl[bvd_pkg::BVD_BIT_IOEN] : ctrl[bvd_pkg::BVD_BIT_MEMEN];
    next_fwd = 1'b0;
    next_blk = 1'b0;
    if (req_in.valid) begin
      if (req_in.upstream) begin
        next_blk = vhit;
        next_fwd = ~vhit & ~req_in.in_window;
      end else if (vhit) begin
        next_fwd = space_en;
        next_blk = ~space_en;
      end else begin
        next_fwd = space_en & req_in.in_window;
        next_blk = ~next_fwd;
      end
    end
  end

  // forward pulse, one cycle after the request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_fwd <= 1'b0;
    end else begin
      req_fwd <= next_fwd;
    end
  end

  // refuse pulse, never together with forward
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_blk <= 1'b0;
    end else begin
      req_blk <= next_blk;
    end
  end

  // verdict strobe for the decode pulses
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_done <= 1'b0;
    end else begin
      req_done <= req_in.valid;
    end
  end

  // abort handling per mode
  always_comb begin
    next_verdict = '0;
    if (abort_in.valid) begin
      next_verdict.valid = 1'b1;
      if (abort_in.posted) begin
        if (mode) begin
          next_verdict.discard = 1'b1;
          if (ctrl[bvd_pkg::BVD_BIT_SERR]) begin
            next_verdict.msg_fatal = ctrl[bvd_pkg::BVD_BIT_AER] & ctrl[bvd_pkg::BVD_BIT_FATAL];
            next_verdict.msg_nonfatal = ~next_verdict.msg_fatal;
          end
        end else begin
          next_verdict.discard = 1'b1;
        end
      end else if (mode & pci_mode) begin
        next_verdict.target_abort = 1'b1;
      end else begin
        next_verdict.ret_ones = abort_in.is_read;
        next_verdict.complete_ok = ~abort_in.is_read;
      end
    end
  end

  // abort verdict pulse, one cycle after the abort event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      verdict <= '0;
    end else begin
      verdict <= next_verdict;
    end
  end

  // read data returned for an aborted read, zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      abort_rdata <= '0;
    end else begin
      abort_rdata <= next_verdict.ret_ones ? bvd_pkg::BVD_ALL_ONES : '0;
    end
  end
endmodule

// [bvd_top_monitor.sv]
module bvd_top_monitor (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire bvd_pkg::bvd_req_t req_in, // request
  input wire logic req_fwd, // forwarded
  input wire logic req_blk, // refused
  input wire logic req_done, // decode valid
  input wire logic pci_mode, // pci mode
  input wire bvd_pkg::bvd_abort_t abort_in, // abort
  input wire bvd_pkg::bvd_verdict_t verdict, // handling
  input wire logic [31:0] abort_rdata // aborted read data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // decode and abort verdicts tied to their causes
  AST_RDONE: assert property (req_in.valid |=> req_done && !(req_fwd && req_blk)) else $error("decode");
  AST_VLAT: assert property (abort_in.valid |=> verdict.valid) else $error("late verdict");
  AST_ONES: assert property (verdict.valid |-> abort_rdata == {32{verdict.ret_ones}}) else $error("rdata");
  AST_POST: assert property (abort_in.valid && abort_in.posted |=> verdict.discard && !verdict.ret_ones)
    else $error("posted");
  AST_NOPCI: assert property (abort_in.valid && !pci_mode |=> !verdict.target_abort) else $error("ta");
  AST_SEV: assert property (verdict.valid |-> !(verdict.msg_fatal && verdict.msg_nonfatal)) else $error("sev");
  AST_MEMOUT: assert property (req_in.valid && !req_in.is_io && !req_in.upstream && !req_in.in_window
    && (req_in.addr < 32'h000a_0000 || req_in.addr > 32'h000b_ffff) |=> !req_fwd) else $error("mem fwd");
  AST_IOHI: assert property (req_in.valid && req_in.is_io && !req_in.upstream && !req_in.in_window
    && req_in.addr[31:16] != 16'h0000 |=> !req_fwd) else $error("io fwd");
endmodule
bind bvd_top bvd_top_monitor u_mon (.sys_clk, .rst, .req_in, .req_fwd, .req_blk, .req_done, .pci_mode,
  .abort_in, .verdict, .abort_rdata);

// [tb_bridge_vga_decode_abort_mode.sv]
module tb_bridge_vga_decode_abort_mode;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic ab; logic [31:0] ctrl; logic pm, io, up, win; logic [31:0] a; logic [6:0] e, m;} bvd_row_t;
  logic sys_clk, rst, avs_read, avs_write, pci_mode, req_fwd, req_blk, req_done, avs_waitrequest, irq;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, abort_rdata, q;
  bvd_pkg::bvd_req_t req_in;
  bvd_pkg::bvd_abort_t abort_in;
  bvd_pkg::bvd_verdict_t verdict;
  int error_cnt = 0;
  int total_checks = 0;
  // abort rows: io=posted, up=read; decode rows: e={fwd,blk}
  bvd_row_t rows [18] = '{
    '{1, 0, 1, 0, 1, 0, 0, 7'h60, 7'h70},
    '{1, 0, 1, 0, 0, 0, 0, 7'h48, 7'h58},
    '{1, 0, 1, 1, 0, 0, 0, 7'h44, 7'h57},
    '{1, 32'h0022_0000, 1, 0, 1, 0, 0, 7'h50, 7'h53},
    '{1, 32'h0022_0000, 0, 0, 1, 0, 0, 7'h60, 7'h70},
    '{1, 32'h0022_0000, 1, 1, 0, 0, 0, 7'h46, 7'h57},
    '{1, 32'h0022_000c, 1, 1, 0, 0, 0, 7'h45, 7'h57},
    '{1, 32'h0020_000c, 1, 1, 0, 0, 0, 7'h44, 7'h57},
    '{0, 32'h0008_0002, 0, 0, 0, 0, 32'h000b_ffff, 7'h2, 7'h3},
    '{0, 32'h0008_0002, 0, 0, 0, 0, 32'h000c_0000, 7'h1, 7'h3},
    '{0, 32'h0008_0001, 0, 1, 0, 0, 32'h0000_03bb, 7'h2, 7'h3},
    '{0, 32'h0008_0001, 0, 1, 0, 0, 32'h0001_03c0, 7'h1, 7'h3},
    '{0, 32'h0008_0001, 0, 1, 0, 0, 32'h0000_7fdf, 7'h2, 7'h3},
    '{0, 32'h0018_0001, 0, 1, 0, 0, 32'h0000_7fdf, 7'h1, 7'h3},
    '{0, 32'h0010_0001, 0, 1, 0, 1, 32'h0000_7fdf, 7'h2, 7'h3},
    '{0, 32'h0008_0000, 0, 1, 0, 0, 32'h0000_03c0, 7'h1, 7'h3},
    '{0, 32'h0008_0002, 0, 0, 1, 0, 32'h000a_0000, 7'h1, 7'h3},
    '{0, 32'h000c_0002, 0, 0, 0, 0, 32'h000a_0000, 7'h2, 7'h3}};
  bvd_top u_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .req_in, .req_fwd, .req_blk, .req_done, .pci_mode, .abort_in, .verdict,
    .abort_rdata, .irq);
  bvd_far_model u_far (.sys_clk, .req_in, .abort_in);
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic ok, input string s);
    total_checks++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, s);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    check(n < 50, "bus hang");
    avs_write <= 0;
    avs_read <= 0;
    @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata, pci_mode} = {1'b1, 38'h0};
    avs_byteenable = 4'hf;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    bus(0, 4'h0, 0);
    check(q === 32'h0, "ctrl reset");
    bus(1, 4'h0, 32'hffff_ffff);
    bus(0, 4'h0, 0);
    check(q === bvd_pkg::BVD_CTRL_WMASK, "ctrl rw");
    bus(0, 4'hc, 0);
    check(q === 32'h0, "unmapped");
    foreach (rows[i]) begin
      bus(1, 4'h0, rows[i].ctrl);
      pci_mode <= rows[i].pm;
      if (rows[i].ab) u_far.send_abort(rows[i].io, rows[i].up);
      else u_far.send_req(rows[i].io, rows[i].up, rows[i].win, rows[i].a);
      #1;
      check(((rows[i].ab ? verdict : {req_fwd, req_blk}) & rows[i].m) === (rows[i].e & rows[i].m), "row");
      check(rows[i].ab ? (abort_rdata === {32{rows[i].e[5]}}) : (req_done === 1'b1), "aux");
      @(posedge sys_clk);
    end
    // target-abort event raises a masked-in interrupt
    bus(1, 4'h4, 32'hf);
    bus(1, 4'h8, 32'h1);
    bus(1, 4'h0, 32'h0022_0000);
    check(irq === 1'b0, "irq idle");
    pci_mode <= 1;
    u_far.send_abort(0, 1);
    repeat (3) @(posedge sys_clk);
    check(irq === 1'b1, "irq set");
    bus(1, 4'h8, 0);
    repeat (2) @(posedge sys_clk);
    check(irq === 1'b0, "irq masked");
    bus(0, 4'h4, 0);
    check(q[0] === 1'b1, "sticky");
    bus(1, 4'h4, 32'h1);
    bus(0, 4'h4, 0);
    check(q[0] === 1'b0, "w1c");
    // reset in mid-run clears the control fields and idles the bus
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    check(avs_waitrequest === 1'b1 && irq === 1'b0 && req_done === 1'b0, "reset idle");
    rst <= 0;
    @(posedge sys_clk);
    bus(0, 4'h0, 0);
    check(q === 32'h0, "ctrl mid reset");
    // a single byte lane only reaches its own control bits
    avs_byteenable <= 4'h4;
    bus(1, 4'h0, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    bus(0, 4'h0, 0);
    check(q === (bvd_pkg::BVD_CTRL_WMASK & 32'h00ff_0000), "byte lane");
    tally_and_finish();
  end
endmodule
